// ==== rtl/rma_defines.vh ====
`ifndef RMA_DEFINES_VH
`define RMA_DEFINES_VH
// opcodes of the module-specific actions
`define RMA_OP_READ_PHYS 8'h00
`define RMA_OP_READ_PROG 8'h01
`define RMA_OP_WRITE_OUT 8'h02
`define RMA_OP_WRITE_MODE 8'h03
`define RMA_OP_READ_MODE 8'h04
`define RMA_OP_WRITE_PULSE 8'h05
`define RMA_OP_READ_PULSE 8'h06
// channel count and highest legal channel byte
`define RMA_CHANNELS 16
`define RMA_MAX_CHANNEL 8'h0F
// longest response message on the smallest host
`define RMA_MAX_RSP_BYTES 11
// timing: clock rate, tick period, debounce window
`define RMA_CLOCK_HZ 50000000
`define RMA_TICK_US 2000
`define RMA_TICK_CYCLES ((`RMA_CLOCK_HZ / 1000000) * `RMA_TICK_US)
`define RMA_DEBOUNCE_MS 10
`define RMA_DEBOUNCE_SAMPLES (`RMA_DEBOUNCE_MS * 1000 / `RMA_TICK_US)
// reset values
`define RMA_MODE_RESET 16'h0000
`define RMA_DRIVE_RESET 16'h0000
`endif

// ==== rtl/rma_debounce.v ====
`timescale 1ns/100ps
`default_nettype none
// per-channel filter: a state is taken only after it holds for the whole window
module rma_debounce #(
   parameter WIDTH = 16,
   parameter SAMPLES = 5
) (
   // clock and reset
   input wire clock,
   input wire sys_rst,
   // sample strobe and raw inputs
   input wire tick,
   input wire [WIDTH-1:0] raw,
   // filtered states
   output wire [WIDTH-1:0] stable
);
   genvar g;
   generate
      for (g = 0; g < WIDTH; g = g + 1) begin : chan
         reg [2:0] run;
         reg last;
         reg value;
         // count consecutive equal samples; accept at the window length
         always @(posedge clock) begin
            if (sys_rst) begin
               run <= 3'h0;
               last <= 1'b0;
               value <= 1'b0;
            end else if (tick) begin
               last <= raw[g];
               if (raw[g] != last) begin
                  run <= 3'h1;
               end else if (run < SAMPLES[2:0]) begin
                  run <= run + 3'h1;
               end
               if (raw[g] == last && run >= SAMPLES[2:0] - 3'h1) begin
                  value <= raw[g];
               end
            end
         end
         assign stable[g] = value;
      end
   endgenerate
endmodule // rma_debounce
`default_nettype wire

// ==== rtl/rma_pulse_store.v ====
`timescale 1ns/100ps
`default_nettype none
// per-channel pulse timing store: active and idle times in tick units
module rma_pulse_store #(
   parameter CHANNELS = 16
) (
   // clock and reset
   input wire clock,
   input wire sys_rst,
   // write port
   input wire wr_en,
   input wire [3:0] wr_chan,
   input wire [7:0] wr_active,
   input wire [7:0] wr_idle,
   // duty clear for channels entering pulse mode
   input wire [CHANNELS-1:0] clear_active,
   // read port, combinational
   input wire [3:0] rd_chan,
   output wire [7:0] rd_active,
   output wire [7:0] rd_idle
);
   reg [7:0] active_mem [0:CHANNELS-1];
   reg [7:0] idle_mem [0:CHANNELS-1];
   genvar g;
   generate
      for (g = 0; g < CHANNELS; g = g + 1) begin : entry
         // clear wins over a write in the same cycle so a fresh mode change stays safe
         always @(posedge clock) begin
            if (sys_rst) begin
               active_mem[g] <= 8'h00;
               idle_mem[g] <= 8'h00;
            end else begin
               if (clear_active[g]) begin
                  active_mem[g] <= 8'h00;
               end else if (wr_en && wr_chan == g) begin
                  active_mem[g] <= wr_active;
               end
               if (wr_en && wr_chan == g) begin
                  idle_mem[g] <= wr_idle;
               end
            end
         end
      end
   endgenerate
   assign rd_active = active_mem[rd_chan];
   assign rd_idle = idle_mem[rd_chan];
endmodule // rma_pulse_store
`default_nettype wire

// ==== rtl/rma_action_handler.v ====
`timescale 1ns/100ps
`default_nettype none
`include "rma_defines.vh"
////////////////////////////////////////////////////////////////////////////////
module rma_action_handler #(
   parameter CHANNELS = `RMA_CHANNELS,
   parameter TICK_CYCLES = `RMA_TICK_CYCLES
) (
   // clock and reset
   input wire clock,
   input wire sys_rst,
   // command byte stream
   input wire cmd_valid,
   input wire [7:0] cmd_byte,
   input wire cmd_start,
   output reg cmd_ready,
   // response byte stream
   output reg rsp_valid,
   output reg [7:0] rsp_byte,
   output reg rsp_last,
   output reg act_done,
   output reg act_refused,
   // channel pins
   input wire [CHANNELS-1:0] chan_in,
   output reg [CHANNELS-1:0] chan_drive,
   // status
   output reg [CHANNELS-1:0] channel_mode,
   output reg tick
);
   // one-hot states
   localparam ST_OPCODE = 6'h01;
   localparam ST_ARG0 = 6'h02;
   localparam ST_ARG1 = 6'h04;
   localparam ST_ARG2 = 6'h08;
   localparam ST_RSP = 6'h10;
   localparam ST_DONE = 6'h20;

   ////////////////////////////////////////////////////////////////////////////
   // sampling and update tick
   reg [31:0] tick_count;
   always @(posedge clock) begin
      if (sys_rst) begin
         tick_count <= 32'h00000000;
         tick <= 1'b0;
      end else if (tick_count == TICK_CYCLES - 1) begin
         tick_count <= 32'h00000000;
         tick <= 1'b1;
      end else begin
         tick_count <= tick_count + 32'h00000001;
         tick <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // debounced inputs and pulse timing store
   wire [CHANNELS-1:0] phys_state;
   rma_debounce #(
      .WIDTH(CHANNELS),
      .SAMPLES(`RMA_DEBOUNCE_SAMPLES)
   ) u_debounce (
      .clock(clock),
      .sys_rst(sys_rst),
      .tick(tick),
      .raw(chan_in),
      .stable(phys_state)
   );

   reg state_pwr_wr;
   reg [3:0] pulse_chan;
   reg [7:0] pulse_active;
   reg [7:0] pulse_idle; // held here: the client may drop the byte right after the accept
   reg [CHANNELS-1:0] enter_pulse;
   wire [7:0] rd_active;
   wire [7:0] rd_idle;
   rma_pulse_store #(
      .CHANNELS(CHANNELS)
   ) u_pulse (
      .clock(clock),
      .sys_rst(sys_rst),
      .wr_en(state_pwr_wr),
      .wr_chan(pulse_chan),
      .wr_active(pulse_active),
      .wr_idle(pulse_idle),
      .clear_active(enter_pulse),
      .rd_chan(pulse_chan),
      .rd_active(rd_active),
      .rd_idle(rd_idle)
   );

   ////////////////////////////////////////////////////////////////////////////
   // action sequencer
   reg [5:0] state;
   reg [7:0] opcode;
   reg [7:0] arg_low;
   reg [1:0] rsp_idx;
   reg [1:0] rsp_len;
   reg [15:0] rsp_word;
   reg chan_bad;
   reg [CHANNELS-1:0] pending_drive;
   reg [CHANNELS-1:0] pending_mask;
   reg pending;
   wire take = cmd_valid & cmd_ready;
   wire [CHANNELS-1:0] new_mode = {cmd_byte, arg_low};

   always @(posedge clock) begin
      if (sys_rst) begin
         state <= ST_OPCODE;
         opcode <= 8'h00;
         arg_low <= 8'h00;
         rsp_idx <= 2'h0;
         rsp_len <= 2'h0;
         rsp_word <= 16'h0000;
         chan_bad <= 1'b0;
         pulse_chan <= 4'h0;
         pulse_active <= 8'h00;
         pulse_idle <= 8'h00;
         state_pwr_wr <= 1'b0;
         enter_pulse <= {CHANNELS{1'b0}};
         channel_mode <= `RMA_MODE_RESET;
         cmd_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_byte <= 8'h00;
         rsp_last <= 1'b0;
         act_done <= 1'b0;
         act_refused <= 1'b0;
         pending_drive <= {CHANNELS{1'b0}};
         pending_mask <= {CHANNELS{1'b0}};
         pending <= 1'b0;
      end else begin
         state_pwr_wr <= 1'b0;
         enter_pulse <= {CHANNELS{1'b0}};
         rsp_valid <= 1'b0;
         rsp_last <= 1'b0;
         act_done <= 1'b0;
         act_refused <= 1'b0;
         cmd_ready <= 1'b0;
         if (tick) begin
            pending <= 1'b0; // deferred write consumed by the driver stage
         end
         case (state)
            ST_OPCODE: begin
               cmd_ready <= ~take;
               if (take) begin
                  opcode <= cmd_byte; // each action runs to its end before the next
                  cmd_ready <= 1'b0;
                  case (cmd_byte)
                     `RMA_OP_READ_PHYS: begin
                        rsp_word <= phys_state; // all channels, any mode
                        rsp_len <= 2'h2;
                        rsp_idx <= 2'h0;
                        state <= ST_RSP;
                     end
                     `RMA_OP_READ_PROG: begin
                        rsp_word <= chan_drive; // pulse-mode bits undefined
                        rsp_len <= 2'h2;
                        rsp_idx <= 2'h0;
                        state <= ST_RSP;
                     end
                     `RMA_OP_READ_MODE: begin
                        rsp_word <= channel_mode;
                        rsp_len <= 2'h2;
                        rsp_idx <= 2'h0;
                        state <= ST_RSP;
                     end
                     `RMA_OP_WRITE_OUT, `RMA_OP_WRITE_MODE, `RMA_OP_WRITE_PULSE, `RMA_OP_READ_PULSE: begin
                        state <= ST_ARG0;
                     end
                     default: begin
                        act_refused <= 1'b1; // no state touched
                        state <= ST_DONE;
                     end
                  endcase
               end
            end
            ST_ARG0: begin
               cmd_ready <= ~take;
               if (take) begin
                  arg_low <= cmd_byte;
                  pulse_chan <= cmd_byte[3:0];
                  chan_bad <= cmd_byte > `RMA_MAX_CHANNEL;
                  if (opcode == `RMA_OP_READ_PULSE) begin
                     state <= ST_RSP;
                     rsp_len <= 2'h2;
                     rsp_idx <= 2'h0;
                     rsp_word <= 16'h0000;
                     if (cmd_byte > `RMA_MAX_CHANNEL) begin
                        rsp_len <= 2'h0; // bad channel: answer nothing
                        act_refused <= 1'b1;
                        state <= ST_DONE;
                     end
                  end else begin
                     state <= ST_ARG1;
                  end
               end
            end
            ST_ARG1: begin
               cmd_ready <= ~take;
               if (take) begin
                  state <= ST_DONE;
                  if (opcode == `RMA_OP_WRITE_OUT) begin
                     // latch for the next tick; pulse channels masked out
                     pending_drive <= {cmd_byte, arg_low};
                     pending_mask <= ~channel_mode;
                     pending <= 1'b1;
                  end else if (opcode == `RMA_OP_WRITE_MODE) begin
                     enter_pulse <= new_mode & ~channel_mode;
                     channel_mode <= new_mode;
                  end else begin
                     pulse_active <= cmd_byte; // 2 ms units, full byte range
                     state <= ST_ARG2;
                  end
               end
            end
            ST_ARG2: begin
               cmd_ready <= ~take;
               if (take) begin
                  pulse_idle <= cmd_byte;
                  state_pwr_wr <= ~chan_bad;
                  act_refused <= chan_bad;
                  state <= ST_DONE;
               end
            end
            ST_RSP: begin
               rsp_valid <= 1'b1; // at most two bytes per action, well under the cap
               if (opcode == `RMA_OP_READ_PULSE) begin
                  rsp_byte <= (rsp_idx == 2'h0) ? rd_active : rd_idle;
               end else begin
                  rsp_byte <= (rsp_idx == 2'h0) ? rsp_word[7:0] : rsp_word[15:8]; // low first
               end
               rsp_last <= rsp_idx == rsp_len - 2'h1;
               rsp_idx <= rsp_idx + 2'h1;
               if (rsp_idx == rsp_len - 2'h1) begin
                  state <= ST_DONE;
               end
            end
            ST_DONE: begin
               act_done <= 1'b1; // acknowledged no later than the driver moves
               state <= ST_OPCODE;
            end
            default: begin
               state <= ST_OPCODE;
            end
         endcase
         if (cmd_start && state == ST_OPCODE && !take) begin
            state <= ST_OPCODE; // message boundary: stay ready for the first opcode
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // driver stage: standard channels from the deferred write, pulse channels from timing
   reg [CHANNELS-1:0] mode_seen;
   wire [CHANNELS-1:0] pulse_level;
   genvar g;
   generate
      for (g = 0; g < CHANNELS; g = g + 1) begin : pwm
         reg [8:0] phase;
         reg [7:0] on_t;
         reg [7:0] off_t;
         reg level;
         // simple per-channel waveform; detail of the shaping is not critical here
         always @(posedge clock) begin
            if (sys_rst || !channel_mode[g] || enter_pulse[g]) begin
               phase <= 9'h000;
               on_t <= 8'h00;
               off_t <= 8'h00;
               level <= 1'b0;
            end else begin
               if (state_pwr_wr && pulse_chan == g) begin
                  on_t <= pulse_active;
                  off_t <= pulse_idle;
               end
               if (tick) begin
                  if (phase + 9'h001 >= {1'b0, on_t} + {1'b0, off_t}) begin
                     phase <= 9'h000;
                  end else begin
                     phase <= phase + 9'h001;
                  end
                  level <= phase < {1'b0, on_t};
               end
            end
         end
         assign pulse_level[g] = level;
      end
   endgenerate

   always @(posedge clock) begin
      if (sys_rst) begin
         chan_drive <= `RMA_DRIVE_RESET;
         mode_seen <= `RMA_MODE_RESET;
      end else begin
         mode_seen <= channel_mode;
         // all bits of a deferred write switch on one tick; channels entering standard go off at once, off the tick
         chan_drive <= (channel_mode & pulse_level) |
                       (~channel_mode & mode_seen & {CHANNELS{1'b0}}) | // entering standard: forced off
                       (~channel_mode & ~mode_seen &
                        ((tick && pending) ? ((pending_drive & pending_mask) | (chan_drive & ~pending_mask))
                                           : chan_drive));
      end
   end
endmodule // rma_action_handler
`default_nettype wire

// ==== test/rma_handler_checker.sv ====
`timescale 1ns/100ps
`default_nettype none
// port-level checks of the action handler
module rma_handler_checker #(
   parameter CHANNELS = 16,
   parameter TICK_CYCLES = 10
) (
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // command and response handshake
   input wire logic cmd_valid,
   input wire logic cmd_ready,
   input wire logic rsp_valid,
   input wire logic rsp_last,
   input wire logic act_done,
   input wire logic act_refused,
   // channel state
   input wire logic [CHANNELS-1:0] chan_drive,
   input wire logic [CHANNELS-1:0] channel_mode,
   input wire logic tick
);
   logic [CHANNELS-1:0] prev_mode;
   logic [CHANNELS-1:0] left_q;
   int gap;
   logic seen;
   ///////////////////////////////////////////////////////////////////////
   // mode history and tick spacing; seen hides the first gap, one cycle longer since it counts from reset
   always @(posedge clock) begin
      if (sys_rst) begin
         prev_mode <= '0;
         left_q <= '0;
         gap <= 0;
         seen <= 1'b0;
      end else begin
         prev_mode <= channel_mode;
         left_q <= prev_mode & ~channel_mode;
         gap <= tick ? 0 : gap + 1;
         seen <= seen | tick;
      end
   end
   ///////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   // a read answer: two bytes back to back, then completion
   sequence s_rsp_pair;
      rsp_valid && !rsp_last ##1 rsp_valid && rsp_last;
   endsequence
   sequence s_finish;
      !rsp_valid && act_done;
   endsequence
   a_reset_safe: assert property (disable iff (1'b0) sys_rst |=> chan_drive == '0 && channel_mode == '0)
      else $error("drivers or modes not cleared by reset");
   a_ready_drop: assert property (cmd_valid && cmd_ready |=> !cmd_ready)
      else $error("byte accepted on consecutive cycles");
   a_rsp_pair: assert property (rsp_valid && !rsp_last |-> s_rsp_pair ##1 s_finish)
      else $error("read answer not two bytes then done");
   a_rsp_bound: assert property (rsp_last |-> rsp_valid ##1 s_finish)
      else $error("response runs past its last byte");
   a_refuse_done: assert property (act_refused |=> act_done && !rsp_valid)
      else $error("refusal without completion");
   a_done_pulse: assert property (act_done |=> !act_done)
      else $error("completion longer than one cycle");
   a_tick_gap: assert property (tick && seen |-> gap == TICK_CYCLES - 1)
      else $error("tick spacing wrong");
   a_drive_on_tick: assert property ((chan_drive & ~$past(chan_drive)) != '0 |-> $past(tick))
      else $error("driver went active off the tick");
   a_leave_idle: assert property (left_q != '0 |-> (chan_drive & left_q) == '0)
      else $error("driver active after return to standard");
endmodule // rma_handler_checker
`default_nettype wire

// ==== test/rma_client.sv ====
`timescale 1ns/100ps
`default_nettype none
// network client: sends action bytes, gathers answers
module rma_client (
   // clock
   input wire logic clock,
   // command side
   input wire logic cmd_ready,
   output logic cmd_valid,
   output logic [7:0] cmd_byte,
   output logic cmd_start,
   // response side
   input wire logic rsp_valid,
   input wire logic [7:0] rsp_byte,
   input wire logic act_done,
   input wire logic act_refused
);
   logic [7:0] rsp_q[$];
   int done_cnt;
   int ref_cnt;
   int stalls;
   initial begin
      cmd_valid = 1'b0;
      cmd_byte = 8'h5A;
      cmd_start = 1'b0;
      done_cnt = 0;
      ref_cnt = 0;
      stalls = 0;
   end
   // answers are gathered per action; no action here returns over two bytes
   always @(posedge clock) begin
      if (rsp_valid) rsp_q.push_back(rsp_byte);
      if (act_done) done_cnt++;
      if (act_refused) ref_cnt++;
   end
   // one byte, held until taken; a released line shows the inverse, not the old value
   task send_byte(input logic [7:0] b, input logic first, input int slow);
      int i;
      repeat (slow) @(posedge clock);
      @(posedge clock);
      cmd_valid <= 1'b1;
      cmd_byte <= b;
      cmd_start <= first;
      i = 0;
      do begin
         @(posedge clock);
         i++;
      end while (!cmd_ready && i < 50);
      if (!cmd_ready) stalls++;
      cmd_valid <= 1'b0;
      cmd_start <= 1'b0;
      cmd_byte <= ~b;
   endtask
endmodule // rma_client
`default_nettype wire

// ==== test/rma_action_handler_test.sv ====
`timescale 1ns/100ps
`default_nettype none
module rma_action_handler_test;
   localparam int TK = 10;
   logic clock, sys_rst, cmd_valid, cmd_start, cmd_ready, rsp_valid, rsp_last, act_done, act_refused, tick;
   logic [7:0] cmd_byte, rsp_byte, on, off;
   logic [15:0] chan_in, chan_drive, channel_mode, mode_m, drive_m, v;
   logic [7:0] act_m[16];
   logic [7:0] idle_m[16];
   int errors, num_checks, rnd, ch, rd;
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   rma_action_handler #(.CHANNELS(16), .TICK_CYCLES(TK)) dut_u (.clock(clock), .sys_rst(sys_rst),
      .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .cmd_start(cmd_start), .cmd_ready(cmd_ready),
      .rsp_valid(rsp_valid), .rsp_byte(rsp_byte), .rsp_last(rsp_last), .act_done(act_done),
      .act_refused(act_refused), .chan_in(chan_in), .chan_drive(chan_drive),
      .channel_mode(channel_mode), .tick(tick));
   rma_client client_u (.clock(clock), .cmd_ready(cmd_ready), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
      .cmd_start(cmd_start), .rsp_valid(rsp_valid), .rsp_byte(rsp_byte), .act_done(act_done),
      .act_refused(act_refused));
   ///////////////////////////////////////////////////////////////////////
   task tally_and_finish;
      errors = errors + client_u.stalls;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one action: opcode, n argument bytes, expected answer count, bytes and refusal
   task act(input logic [7:0] op, a0, a1, a2, input int n, nrsp, input logic [15:0] e, msk, input logic refd);
      int k, r0, sl, i;
      client_u.rsp_q.delete();
      k = client_u.done_cnt;
      r0 = client_u.ref_cnt;
      sl = $urandom % 3;
      client_u.send_byte(op, 1'b1, sl);
      if (n > 0) client_u.send_byte(a0, 1'b0, sl);
      if (n > 1) client_u.send_byte(a1, 1'b0, sl);
      if (n > 2) client_u.send_byte(a2, 1'b0, sl);
      for (i = 0; i < 40 && client_u.done_cnt == k; i++) begin
         @(posedge clock);
         #1;
      end
      if (client_u.done_cnt == k) begin
         errors++;
         $display("[FAIL] act_done expected 1 seen 0");
         tally_and_finish();
      end
      chk("rsp count", 16'(nrsp), 16'(client_u.rsp_q.size()));
      chk("refused", {15'h0000, refd}, 16'(client_u.ref_cnt - r0));
      if (nrsp == 2 && client_u.rsp_q.size() == 2) chk("rsp data", e & msk, {client_u.rsp_q[1], client_u.rsp_q[0]} & msk);
   endtask
   // mode write with model update, then port and readback compare
   task set_modes(input logic [15:0] m);
      int b;
      act(8'h03, m[7:0], m[15:8], 8'h00, 2, 0, 16'h0000, 16'h0000, 1'b0);
      for (b = 0; b < 16; b++) if (m[b] && !mode_m[b]) act_m[b] = 8'h00;
      drive_m = drive_m & ~(mode_m & ~m);
      mode_m = m;
      chk("mode port", mode_m, channel_mode);
      act(8'h04, 8'h00, 8'h00, 8'h00, 0, 2, mode_m, 16'hFFFF, 1'b0);
   endtask
   // wait for the next tick, then let the update edge land
   task apply_chk;
      int k;
      k = 0;
      do begin
         @(posedge clock);
         #1;
         k++;
      end while (tick !== 1'b1 && k < TK + 2);
      if (tick !== 1'b1) begin
         errors++;
         $display("[FAIL] tick expected 1 seen 0");
         tally_and_finish();
      end
      @(posedge clock);
      #1;
      chk("drive", drive_m & ~mode_m, chan_drive & ~mode_m);
   endtask
   ///////////////////////////////////////////////////////////////////////
   initial begin
      sys_rst = 1'b1;
      chan_in = 16'h0000;
      errors = 0;
      num_checks = 0;
      mode_m = 16'h0000;
      drive_m = 16'h0000;
      rnd = $urandom(88877);
      repeat (10) @(posedge clock);
      sys_rst <= 1'b0;
      for (rd = 0; rd < 3; rd++) begin
         @(posedge clock);
         #1;
         chk("reset mode", 16'h0000, channel_mode);
         chk("reset drive", 16'h0000, chan_drive);
         ch = $urandom % 16;
         v = 16'($urandom);
         v[ch] = 1'b0;
         set_modes(v);
         v = 16'($urandom);
         act(8'h02, v[7:0], v[15:8], 8'h00, 2, 0, 16'h0000, 16'h0000, 1'b0);
         drive_m = (drive_m & mode_m) | (v & ~mode_m);
         apply_chk();
         act(8'h01, 8'h00, 8'h00, 8'h00, 0, 2, drive_m, ~mode_m, 1'b0);
         on = 8'($urandom % 255 + 1);
         off = 8'($urandom);
         act(8'h05, 8'(ch), on, off, 3, 0, 16'h0000, 16'h0000, 1'b0);
         act_m[ch] = on;
         idle_m[ch] = off;
         act(8'h06, 8'(ch), 8'h00, 8'h00, 1, 2, {idle_m[ch], act_m[ch]}, 16'hFFFF, 1'b0);
         act(8'h05, 8'($urandom % 240 + 16), 8'hFF, 8'hFF, 3, 0, 16'h0000, 16'h0000, 1'b1);
         act(8'h06, 8'($urandom % 240 + 16), 8'h00, 8'h00, 1, 0, 16'h0000, 16'h0000, 1'b1);
         act(8'($urandom % 249 + 7), 8'h00, 8'h00, 8'h00, 0, 0, 16'h0000, 16'h0000, 1'b1);
         v = 16'($urandom);
         v[ch] = 1'b1;
         set_modes(v);
         act(8'h06, 8'(ch), 8'h00, 8'h00, 1, 2, {idle_m[ch], act_m[ch]}, 16'hFFFF, 1'b0);
         apply_chk();
         @(posedge clock);
         chan_in <= 16'($urandom);
         repeat (10 * TK) @(posedge clock);
         act(8'h00, 8'h00, 8'h00, 8'h00, 0, 2, chan_in, 16'hFFFF, 1'b0);
         // a mid-run reset puts mode_m and drive_m back to their power-up state
         @(posedge clock);
         sys_rst <= 1'b1;
         repeat (3) @(posedge clock);
         sys_rst <= 1'b0;
         mode_m = 16'h0000;
         drive_m = 16'h0000;
      end
      tally_and_finish();
   end
endmodule // rma_action_handler_test
bind rma_action_handler rma_handler_checker #(.CHANNELS(CHANNELS), .TICK_CYCLES(TICK_CYCLES)) chk_u (
   .clock(clock), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
   .rsp_last(rsp_last), .act_done(act_done), .act_refused(act_refused), .chan_drive(chan_drive),
   .channel_mode(channel_mode), .tick(tick));
`default_nettype wire
